// >>> inc/eril_defs.svh
`ifndef ERIL_DEFS_SVH
`define ERIL_DEFS_SVH
// product information field byte positions
`define ERIL_PI_CRC_BYTE      4'hF
`define ERIL_PI_TRIM_HI       4'hE
`define ERIL_PI_TRIM_LO       4'hC
`define ERIL_PI_SER_HI        4'hB
`define ERIL_PI_SER_LO        4'h8
`define ERIL_PI_TYPE_VER      4'h4
`define ERIL_PI_TYPE_LO       4'h0
// register window loaded at start-up
`define ERIL_REG_FIRST        6'h10
`define ERIL_REG_LAST         6'h2F
// page-select register repeats every eight addresses
`define ERIL_PAGE_MASK        6'h07
// crc-8 settings for the information field
`define ERIL_CRC_POLY         8'h07
`define ERIL_CRC_INIT         8'hFF
// nonvolatile read latency in cycles
`define ERIL_NVM_LAT          2'h1
`endif

// >>> inc/eril_pkg.sv
package eril_pkg;
    typedef enum logic [5:0] {
        ERIL_IDLE  = 6'b000001,
        ERIL_PRD   = 6'b000010,
        ERIL_PCHK  = 6'b000100,
        ERIL_CRD   = 6'b001000,
        ERIL_CWR   = 6'b010000,
        ERIL_DONE  = 6'b100000
    } eril_state_e;
    // one register write toward the register file
    typedef struct packed {
        logic       valid;
        logic [5:0] addr;
        logic [7:0] data;
    } eril_wr_s;
endpackage

// >>> logic/eril_crc8.sv
`timescale 1ns/1ps
`include "eril_defs.svh"
module eril_crc8
    import eril_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // byte stream
    input  wire logic       i_clr,
    input  wire logic       i_en,
    input  wire logic [7:0] i_byte,
    // running value
    output logic [7:0]      o_crc
);
    logic [7:0] crc_ff;
    logic [7:0] nxt_crc;
    // bitwise msb-first crc-8 over one byte
    always_comb begin
        nxt_crc = crc_ff ^ i_byte;
        for (int b = 0; b < 8; b++) begin
            nxt_crc = nxt_crc[7] ? ((nxt_crc << 1) ^ `ERIL_CRC_POLY) : (nxt_crc << 1);
        end
    end
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            crc_ff <= `ERIL_CRC_INIT;
        end else if (i_clr) begin
            crc_ff <= `ERIL_CRC_INIT;
        end else if (i_en) begin
            crc_ff <= nxt_crc;
        end
    end
    assign o_crc = crc_ff;
endmodule

// >>> logic/eril_loader.sv
`timescale 1ns/1ps
`include "eril_defs.svh"
// Summary of operation
// - product information bytes are never written; only the read port exists.
// - byte 15 holds crc of the field; checked during start-up.
// - bytes 14 to 12 hold trimming values, read only.
// - bytes 11 to 8 hold a unique serial number.
// - bytes 4 to 0 hold the product type identification.
// - byte 4 reports the current silicon version.
// - start-up loads registers 10h to 2Fh automatically.
// - start-up load source is nonvolatile blocks 1 and 2.
// - load command repeats the register initialization copy.
// - page register at 10h, 18h, 20h, 28h is skipped.
// - nonvolatile byte address maps to same register address.
module eril_loader
    import eril_pkg::*;
(
    // clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_nrst,
    // host command
    input  wire logic       i_register_file_load_command,
    // nonvolatile memory read port, byte addressed
    output logic [5:0]      o_nvm_addr,
    output logic            o_nvm_rd,
    input  wire logic [7:0] i_nvm_data,
    // product information field, fixed by manufacture
    input  wire logic [127:0] i_pinfo,
    // register file write port
    output eril_wr_s        o_reg_wr,
    // status
    output logic            o_busy,
    output logic            o_done,
    output logic            o_crc_ok,
    output logic [31:0]     o_serial,
    output logic [23:0]     o_trim,
    output logic [39:0]     o_type_id
);
    eril_state_e state_ff;
    logic [5:0]  addr_ff;
    logic [3:0]  pidx_ff;
    logic        lat_ff;
    logic        crc_ok_ff;
    logic        done_ff;
    eril_wr_s    wr_ff;
    logic [7:0]  crc_val;
    logic [7:0]  pbyte;
    logic        is_page;
    logic        crc_en;

    // current information byte; the field has no write path at all
    assign pbyte   = i_pinfo[{pidx_ff, 3'h0} +: 8];
    assign is_page = (addr_ff & `ERIL_PAGE_MASK) == 6'h00;
    assign crc_en  = (state_ff == ERIL_PRD) && (pidx_ff != `ERIL_PI_CRC_BYTE);

    eril_crc8 u_crc (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_clr  (state_ff == ERIL_IDLE),
        .i_en   (crc_en),
        .i_byte (pbyte),
        .o_crc  (crc_val)
    );

    // sequencer: start-up runs info check then copy; command runs copy only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_ff <= ERIL_IDLE;
        end else begin
            case (state_ff)
                ERIL_IDLE: state_ff <= done_ff ? ERIL_IDLE : ERIL_PRD;
                ERIL_PRD:  state_ff <= (pidx_ff == `ERIL_PI_CRC_BYTE) ? ERIL_PCHK : ERIL_PRD;
                ERIL_PCHK: state_ff <= ERIL_CRD;
                ERIL_CRD: begin
                    if (is_page) begin
                        state_ff <= (addr_ff == `ERIL_REG_LAST) ? ERIL_DONE : ERIL_CRD;
                    end else if (lat_ff) begin
                        state_ff <= ERIL_CWR;
                    end
                end
                ERIL_CWR:  state_ff <= (addr_ff == `ERIL_REG_LAST) ? ERIL_DONE : ERIL_CRD;
                ERIL_DONE: begin
                    // the first done cycle still counts as busy, so a command there is refused
                    if (i_register_file_load_command && done_ff) begin
                        state_ff <= ERIL_CRD;
                    end
                end
                default:   state_ff <= ERIL_IDLE;
            endcase
        end
    end

    // information byte index walks 0 to 15
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            pidx_ff <= 4'h0;
        end else if (state_ff == ERIL_PRD) begin
            pidx_ff <= pidx_ff + 4'h1;
        end
    end

    // crc verdict held until the next power-up
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            crc_ok_ff <= 1'b0;
        end else if (state_ff == ERIL_PCHK) begin
            crc_ok_ff <= (crc_val == i_pinfo[{`ERIL_PI_CRC_BYTE, 3'h0} +: 8]);
        end
    end

    // copy address: ascending from 10h, same address on both sides
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            addr_ff <= `ERIL_REG_FIRST;
        end else if ((state_ff == ERIL_DONE) || (state_ff == ERIL_PCHK)) begin
            addr_ff <= `ERIL_REG_FIRST;
        end else if (((state_ff == ERIL_CRD) && is_page) || (state_ff == ERIL_CWR)) begin
            addr_ff <= addr_ff + 6'h01;
        end
    end

    // one wait cycle for the memory read
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            lat_ff <= 1'b0;
        end else begin
            lat_ff <= (state_ff == ERIL_CRD) && !is_page && !lat_ff;
        end
    end

    // register write carries the byte read from the matching address
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wr_ff <= '0;
        end else begin
            wr_ff.valid <= (state_ff == ERIL_CRD) && !is_page && lat_ff;
            wr_ff.addr  <= addr_ff;
            wr_ff.data  <= i_nvm_data;
        end
    end

    // done raised only once the last write has left
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            done_ff <= 1'b0;
        end else if (state_ff == ERIL_DONE) begin
            done_ff <= !(i_register_file_load_command && done_ff);
        end else if (state_ff != ERIL_IDLE) begin
            done_ff <= 1'b0;
        end
    end

    assign o_nvm_addr = addr_ff;
    assign o_nvm_rd   = (state_ff == ERIL_CRD) && !is_page;
    assign o_reg_wr   = wr_ff;
    assign o_busy     = !done_ff;
    assign o_done     = done_ff;
    assign o_crc_ok   = crc_ok_ff;
    // information fields; serial, trim and type are straight views of the field
    assign o_trim     = i_pinfo[{`ERIL_PI_TRIM_LO, 3'h0} +: 24];
    assign o_serial   = i_pinfo[{`ERIL_PI_SER_LO, 3'h0} +: 32];
    assign o_type_id  = i_pinfo[{`ERIL_PI_TYPE_LO, 3'h0} +: 40];


    // last write address, kept only for the order check
    logic [5:0] last_wr_ff;
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            last_wr_ff <= 6'h00;
        end else if (o_reg_wr.valid) begin
            last_wr_ff <= o_reg_wr.addr;
        end
    end

    // one copied byte: two read cycles, then the write with the read closed
    sequence copy_read_s;
        o_nvm_rd ##1 o_nvm_rd;
    endsequence
    sequence copy_write_s;
        o_reg_wr.valid && !o_nvm_rd;
    endsequence

    // page writes never happen
    page_skip_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_reg_wr.valid |-> (o_reg_wr.addr & `ERIL_PAGE_MASK) != 6'h00)
        else $error("page register written");
    // write window limited to 10h..2Fh
    write_range_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_reg_wr.valid |-> (o_reg_wr.addr >= `ERIL_REG_FIRST && o_reg_wr.addr <= `ERIL_REG_LAST))
        else $error("write outside window");
    // each write lands above the last one; a fresh copy restarts at 11h
    write_order_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_reg_wr.valid |-> o_reg_wr.addr > last_wr_ff || o_reg_wr.addr == 6'h11)
        else $error("writes out of order");
    // a byte takes three cycles, so writes stand at least two idle cycles apart
    write_gap_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_reg_wr.valid |=> (!o_reg_wr.valid)[*2])
        else $error("writes too close");
    // every opened read ends in its own write
    read_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(o_nvm_rd) |-> copy_read_s ##1 copy_write_s)
        else $error("read without write");
    // write address equals the read address one cycle before
    addr_map_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_reg_wr.valid |-> o_reg_wr.addr == $past(o_nvm_addr))
        else $error("address mapping broken");
    // no write while done
    done_quiet_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_done |-> !o_reg_wr.valid)
        else $error("write after done");
    // last write precedes done closely
    last_write_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(o_done) |-> $past(o_reg_wr.valid, 2) && $past(o_reg_wr.addr, 2) == `ERIL_REG_LAST)
        else $error("done without final write");
    // command restarts the copy within four cycles
    cmd_reload_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        (o_done && i_register_file_load_command) |-> ##[1:4] o_nvm_rd)
        else $error("command did not reload");
    // start-up completes without host within bounded time
    startup_copy_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        $rose(i_nrst) |-> ##[20:120] o_done)
        else $error("start-up load missing");
    // serial view tracks field
    serial_view_a: assert property (@(posedge i_clk) disable iff (!i_nrst)
        o_serial == i_pinfo[95:64])
        else $error("serial mismatch");
endmodule

// >>> sim/eril_nvm_model.sv
`timescale 1ns/1ps
module eril_nvm_model (
    // clock
    input  wire logic       i_clk,
    // read port
    input  wire logic [5:0] i_addr,
    input  wire logic       i_rd,
    output logic [7:0]      o_data
);
    // read-only file; a byte follows its address, a closed read shows the inverse
    always @(posedge i_clk) begin
        if (i_rd) begin
            o_data <= {2'h0, i_addr} ^ 8'hC3;
        end else begin
            o_data <= ~o_data;
        end
    end
endmodule

// >>> sim/test_eril_loader.sv
`timescale 1ns/1ps
module test_eril_loader;
    import eril_pkg::*;
    logic         i_clk = 1'b0, i_nrst = 1'b0, cmd = 1'b0;
    logic         nvm_rd, busy, done, crc_ok;
    logic [5:0]   nvm_addr, exp_addr;
    logic [7:0]   nvm_data;
    logic [127:0] pinfo;
    eril_wr_s     reg_wr;
    logic [31:0]  serial;
    logic [23:0]  trim;
    logic [39:0]  type_id;
    int           err_total = 0, n_compared = 0, n_wr;
    eril_loader u_eril_loader (.i_clk(i_clk), .i_nrst(i_nrst),
        .i_register_file_load_command(cmd), .o_nvm_addr(nvm_addr), .o_nvm_rd(nvm_rd),
        .i_nvm_data(nvm_data), .i_pinfo(pinfo), .o_reg_wr(reg_wr), .o_busy(busy),
        .o_done(done), .o_crc_ok(crc_ok), .o_serial(serial), .o_trim(trim),
        .o_type_id(type_id));
    eril_nvm_model u_eril_nvm_model (.i_clk(i_clk), .i_addr(nvm_addr), .i_rd(nvm_rd),
        .o_data(nvm_data));
    always #5 i_clk = ~i_clk;
    task automatic check(input string name, input logic [39:0] seen, input logic [39:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // own crc, msb first, so a shared slip in the design cannot hide
    function automatic logic [7:0] crc_of(input logic [127:0] p);
        logic [7:0] c;
        c = 8'hFF;
        for (int n = 0; n < 15; n++) begin
            c = c ^ p[8*n +: 8];
            for (int b = 0; b < 8; b++) c = c[7] ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        end
        return c;
    endfunction
    // sampled mid-cycle so registered writes have settled
    always @(negedge i_clk) begin
        if (reg_wr.valid === 1'b1) begin
            check("wr_addr", reg_wr.addr, exp_addr);
            check("wr_data", reg_wr.data, {2'h0, exp_addr} ^ 8'hC3);
            n_wr++;
            exp_addr = exp_addr + ((exp_addr[2:0] == 3'h7) ? 6'h2 : 6'h1);
        end
    end
    task automatic do_reset();
        @(negedge i_clk);
        i_nrst = 1'b0;
        n_wr = 0;
        exp_addr = 6'h11;
        repeat (6) @(negedge i_clk);
        check("busy_rst", busy, 1'b1);
        check("crc_rst", crc_ok, 1'b0);
        i_nrst = 1'b1;
    endtask
    // bounded wait, then the whole copy must be in
    task automatic finish_copy();
        for (int k = 0; k < 400 && done !== 1'b1; k++) @(negedge i_clk);
        if (done !== 1'b1) begin
            err_total++;
            end_sim();
        end
        check("n_wr", n_wr, 28);
        check("end_addr", exp_addr, 6'h31);
    endtask
    task automatic t_startup();
        do_reset();
        finish_copy();
        check("crc_ok", crc_ok, 1'b1);
        check("trim", trim, pinfo[119:96]);
        check("serial", serial, pinfo[95:64]);
        check("type_id", type_id, pinfo[39:0]);
    endtask
    task automatic t_command();
        n_wr = 0;
        exp_addr = 6'h11;
        cmd = 1'b1;
        @(negedge i_clk);
        cmd = 1'b0;
        @(negedge i_clk);
        check("done_cmd", done, 1'b0);
        repeat (10) @(negedge i_clk);
        cmd = 1'b1;
        @(negedge i_clk);
        cmd = 1'b0;
        finish_copy();
        repeat (20) @(negedge i_clk);
        check("n_wr_once", n_wr, 28);
        check("crc_hold", crc_ok, 1'b1);
    endtask
    task automatic t_bad_crc();
        pinfo[127:120] = ~pinfo[127:120];
        do_reset();
        finish_copy();
        check("crc_bad", crc_ok, 1'b0);
    endtask
    initial begin
        for (int n = 0; n < 15; n++) pinfo[8*n +: 8] = 8'hA0 + n[7:0];
        pinfo[127:120] = crc_of(pinfo);
        t_startup();
        t_command();
        t_bad_crc();
        end_sim();
    end
endmodule
